// File: verilog/ep_desc_defines.vh
// constants for the usb endpoint descriptor bank: offsets, fields, resets
// assumes byte addressing on the register bus, one descriptor byte per word
`ifndef EP_DESC_DEFINES_VH
`define EP_DESC_DEFINES_VH

// descriptor byte index within one endpoint (byte address = 4 x index)
`define OFF_CONFIG 3'h0
`define OFF_X_BASE 3'h1
`define OFF_X_COUNT 3'h2
`define OFF_SPARE_A 3'h3
`define OFF_SPARE_B 3'h4
`define OFF_Y_BASE 3'h5
`define OFF_Y_COUNT 3'h6
`define OFF_SIZE 3'h7

// byte address of descriptor block d is d x DESC_STRIDE
`define DESC_STRIDE 8'h20
`define ADDR_IRQ_STATUS 8'hC0
`define ADDR_IRQ_MASK 8'hC4

// configuration byte fields
`define CFG_IRQ_EN 2
`define CFG_STALL 3
`define CFG_DOUBLE_BUFFER_ENABLE 4
`define CFG_TOGGLE 5
`define CFG_ISO 6
`define CFG_SERVICE_EN 7

// byte count fields
`define CNT_NAK 7
`define CNT_MSB 6

// reset values of stored bytes
`define RST_BYTE 8'h00
`define RST_IRQ 6'h00

`endif

// File: verilog/ep_desc_slot.v
// one endpoint descriptor: configuration, x/y base, x/y count, size
// assumes the write strobe and manager events come from the same clock
`timescale 1ns/1ps
`default_nettype none
`include "ep_desc_defines.vh"

module ep_desc_slot (
  input wire clk,
  input wire resetn,
  input wire wr_en,
  input wire [2:0] wr_off,
  input wire [7:0] wr_data,
  input wire done,
  input wire [6:0] done_len,
  input wire done_is_out,
  input wire stall_set,
  output reg [7:0] config_byte,
  output reg [7:0] x_base,
  output reg [7:0] x_count,
  output reg [7:0] y_base,
  output reg [7:0] y_count,
  output reg [7:0] buf_size,
  output wire use_y,
  output wire accepted
);

  assign use_y = config_byte[`CFG_DOUBLE_BUFFER_ENABLE] & config_byte[`CFG_TOGGLE]; // RL9 RL15
  assign accepted = done & config_byte[`CFG_SERVICE_EN]; // RL12

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (!resetn) begin
      config_byte <= `RST_BYTE; // RL8
      x_base <= `RST_BYTE;
      x_count <= `RST_BYTE;
      y_base <= `RST_BYTE;
      y_count <= `RST_BYTE;
      buf_size <= `RST_BYTE;
    end else begin
      if (wr_en) begin
        case (wr_off)
          `OFF_CONFIG: config_byte <= {wr_data[7:2], 2'b00}; // RL8
          `OFF_X_BASE: x_base <= wr_data; // RL13
          `OFF_X_COUNT: x_count <= wr_data; // RL1
          `OFF_Y_BASE: y_base <= wr_data; // RL4
          `OFF_Y_COUNT: y_count <= wr_data; // RL2
          `OFF_SIZE: buf_size <= {1'b0, wr_data[6:0]}; // RL6
          default: begin
          end
        endcase
      end
      // manager update wins over a software write in the same cycle
      if (accepted) begin
        config_byte[`CFG_TOGGLE] <= ~config_byte[`CFG_TOGGLE]; // RL10
        if (use_y) begin
          y_count <= {1'b1, done_is_out ? done_len : y_count[`CNT_MSB:0]}; // RL16 RL3
        end else begin
          x_count <= {1'b1, done_is_out ? done_len : x_count[`CNT_MSB:0]}; // RL16 RL3
        end
      end
      if (stall_set) begin
        config_byte[`CFG_STALL] <= 1'b1; // RL8
      end
    end
  end

endmodule // ep_desc_slot
`default_nettype wire

// File: verilog/usb_endpoint_descriptor_bank.v
// descriptor bank for three out and three in endpoints, avalon-mm slave
// assumes buffer manager signals are synchronous to clk
//
// Summary of operation
// RL1: out x count: 0..64 bytes, binary
// RL2: out y count: same 0..64 encoding
// RL3: out count bit 7 set means buffer full
// RL4: y base extended by three zero bits
// RL5: base registers never changed by transactions
// RL6: size byte 6..0, bit 7 reads zero
// RL7: interrupt enable gates completion interrupt
// RL8: stall resets 0, manager sets, software both
// RL9: double buffer off means x only
// RL10: toggle bit tracks data0/data1 sequence
// RL11: software keeps isochronous bit cleared
// RL12: service enable gates buffer manager use
// RL13: in x base extended to 11 bits
// RL14: eight byte descriptor layout per endpoint
// RL15: toggle 0 picks x, 1 picks y
// RL16: out completion stores length, sets nak
`timescale 1ns/1ps
`default_nettype none
`include "ep_desc_defines.vh"

module usb_endpoint_descriptor_bank #(
  parameter NUM_EP = 6
) (
  input wire clk,
  input wire resetn,
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output wire waitrequest,
  input wire [2:0] mgr_sel,
  input wire mgr_done,
  input wire [6:0] mgr_len,
  input wire mgr_stall,
  output reg [10:0] mgr_start_addr,
  output reg mgr_use_y,
  output reg mgr_enabled,
  output reg mgr_stalled,
  output reg mgr_buf_nak,
  output reg [6:0] mgr_count,
  output reg [6:0] mgr_size,
  output reg mgr_toggle,
  output wire irq
);

  // out endpoints occupy slots 0..2, in endpoints slots 3..5
  localparam [2:0] FIRST_IN = 3'h3;

  function [10:0] start_addr;
    input [7:0] base;
    begin
      start_addr = {base, 3'b000};
    end
  endfunction

  function [2:0] slot_of;
    input [7:0] addr;
    begin
      slot_of = addr[7:5];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait state, answer on the second edge
  reg ack;
  wire req;
  wire do_write;
  wire [2:0] bus_slot;
  wire [2:0] bus_off;
  wire bus_in_bank;

  assign req = read | write;
  assign waitrequest = req & ~ack;
  assign do_write = write & ack & byteenable[0];
  assign bus_slot = slot_of(address);
  assign bus_off = address[4:2];
  assign bus_in_bank = (bus_slot < NUM_EP) & (address[1:0] == 2'b00);

  always @(posedge clk) begin
    if (!resetn) begin
      ack <= 1'b0;
    end else if (req & ~ack) begin
      ack <= 1'b1;
    end else begin
      ack <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // descriptor slots
  wire [8*NUM_EP-1:0] cfg_all;
  wire [8*NUM_EP-1:0] xb_all;
  wire [8*NUM_EP-1:0] xc_all;
  wire [8*NUM_EP-1:0] yb_all;
  wire [8*NUM_EP-1:0] yc_all;
  wire [8*NUM_EP-1:0] sz_all;
  wire [NUM_EP-1:0] use_y_all;
  wire [NUM_EP-1:0] accepted_all;

  genvar g;
  generate
    for (g = 0; g < NUM_EP; g = g + 1) begin : slot
      ep_desc_slot u_slot (
        .clk(clk),
        .resetn(resetn),
        .wr_en(do_write & bus_in_bank & (bus_slot == g)), // RL14
        .wr_off(bus_off),
        .wr_data(writedata[7:0]),
        .done(mgr_done & (mgr_sel == g)),
        .done_len(mgr_len),
        .done_is_out(g < FIRST_IN),
        .stall_set(mgr_stall & (mgr_sel == g)),
        .config_byte(cfg_all[8*g+7:8*g]),
        .x_base(xb_all[8*g+7:8*g]),
        .x_count(xc_all[8*g+7:8*g]),
        .y_base(yb_all[8*g+7:8*g]),
        .y_count(yc_all[8*g+7:8*g]),
        .buf_size(sz_all[8*g+7:8*g]),
        .use_y(use_y_all[g]),
        .accepted(accepted_all[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // interrupt status, write one to clear, and mask, written directly
  reg [NUM_EP-1:0] irq_status;
  reg [NUM_EP-1:0] irq_mask;
  reg [NUM_EP-1:0] irq_event;
  integer i;

  always @* begin
    for (i = 0; i < NUM_EP; i = i + 1) begin
      irq_event[i] = accepted_all[i] & cfg_all[8*i+`CFG_IRQ_EN]; // RL7
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      irq_status <= {NUM_EP{1'b0}};
      irq_mask <= {NUM_EP{1'b0}};
    end else begin
      // a new event in the clearing cycle survives the clear
      if (do_write & (address == `ADDR_IRQ_STATUS)) begin
        irq_status <= (irq_status & ~writedata[NUM_EP-1:0]) | irq_event;
      end else begin
        irq_status <= irq_status | irq_event;
      end
      if (do_write & (address == `ADDR_IRQ_MASK)) begin
        irq_mask <= writedata[NUM_EP-1:0];
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////
  // read path
  reg [7:0] sel_byte;

  always @* begin
    sel_byte = 8'h00;
    case (bus_off)
      `OFF_CONFIG: sel_byte = cfg_all[8*bus_slot+:8];
      `OFF_X_BASE: sel_byte = xb_all[8*bus_slot+:8];
      `OFF_X_COUNT: sel_byte = xc_all[8*bus_slot+:8];
      `OFF_Y_BASE: sel_byte = yb_all[8*bus_slot+:8];
      `OFF_Y_COUNT: sel_byte = yc_all[8*bus_slot+:8];
      `OFF_SIZE: sel_byte = sz_all[8*bus_slot+:8]; // RL6
      default: sel_byte = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (!resetn) begin
      readdata <= 32'h0000_0000;
    end else if (read & ~ack) begin
      if (bus_in_bank) begin
        readdata <= {24'h00_0000, sel_byte};
      end else if (address == `ADDR_IRQ_STATUS) begin
        readdata <= {{(32-NUM_EP){1'b0}}, irq_status};
      end else if (address == `ADDR_IRQ_MASK) begin
        readdata <= {{(32-NUM_EP){1'b0}}, irq_mask};
      end else begin
        readdata <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // buffer manager lookup, registered one cycle after mgr_sel
  // base bytes are only read here, so a transaction never alters them
  wire [7:0] m_cfg;
  wire [7:0] m_xc;
  wire [7:0] m_yc;
  wire m_use_y;

  assign m_cfg = cfg_all[8*mgr_sel+:8];
  assign m_xc = xc_all[8*mgr_sel+:8];
  assign m_yc = yc_all[8*mgr_sel+:8];
  assign m_use_y = use_y_all[mgr_sel];

  always @(posedge clk) begin
    if (!resetn) begin
      mgr_start_addr <= 11'h000;
      mgr_use_y <= 1'b0;
      mgr_enabled <= 1'b0;
      mgr_stalled <= 1'b0;
      mgr_buf_nak <= 1'b0;
      mgr_count <= 7'h00;
      mgr_size <= 7'h00;
      mgr_toggle <= 1'b0;
    end else if (mgr_sel < NUM_EP) begin
      if (m_use_y) begin
        mgr_start_addr <= start_addr(yb_all[8*mgr_sel+:8]); // RL4 RL5 RL15
        mgr_buf_nak <= m_yc[`CNT_NAK]; // RL3
        mgr_count <= m_yc[`CNT_MSB:0]; // RL2
      end else begin
        mgr_start_addr <= start_addr(xb_all[8*mgr_sel+:8]); // RL13 RL5 RL9
        mgr_buf_nak <= m_xc[`CNT_NAK]; // RL3
        mgr_count <= m_xc[`CNT_MSB:0]; // RL1
      end
      mgr_use_y <= m_use_y;
      mgr_enabled <= m_cfg[`CFG_SERVICE_EN]; // RL12
      mgr_stalled <= m_cfg[`CFG_STALL]; // RL8
      mgr_size <= sz_all[8*mgr_sel+:7]; // RL6
      mgr_toggle <= m_cfg[`CFG_TOGGLE]; // RL10
    end else begin
      mgr_enabled <= 1'b0;
    end
  end

endmodule // usb_endpoint_descriptor_bank
`default_nettype wire

// File: verif/ep_desc_monitor.sv
// checker on the manager-side ports of the descriptor bank
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module ep_desc_monitor (
  input wire logic clk,
  input wire logic resetn,
  input wire logic write,
  input wire logic [2:0] mgr_sel,
  input wire logic mgr_done,
  input wire logic [6:0] mgr_len,
  input wire logic mgr_stall,
  input wire logic [10:0] mgr_start_addr,
  input wire logic mgr_use_y,
  input wire logic mgr_enabled,
  input wire logic mgr_stalled,
  input wire logic mgr_buf_nak,
  input wire logic [6:0] mgr_count,
  input wire logic mgr_toggle,
  input wire logic irq
);
  logic [2:0] prev_sel;
  logic prev_ev;
  // lookups lag one edge, so only judge events on a settled slot
  wire steady = mgr_sel == prev_sel && !prev_ev;
  wire go = steady && mgr_done && mgr_enabled;
  always @(posedge clk) begin
    prev_sel <= mgr_sel;
    prev_ev <= mgr_done | mgr_stall;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  //////////////////////////////////////////////////////////////
  property p_start_low; mgr_enabled |-> mgr_start_addr[2:0] == 3'h0; endproperty
  a_start_low: assert property (p_start_low) else $error("start not aligned");
  property p_base_kept;
    steady && mgr_done |=> ##1 mgr_use_y != $past(mgr_use_y, 2) || mgr_start_addr == $past(mgr_start_addr, 2);
  endproperty
  a_base_kept: assert property (p_base_kept) else $error("base moved");
  property p_store;
    go |=> ##1 mgr_use_y != $past(mgr_use_y, 2) || mgr_buf_nak && (mgr_sel > 2 || mgr_count == $past(mgr_len, 2));
  endproperty
  a_store: assert property (p_store) else $error("count not stored");
  property p_toggle; go |=> ##1 mgr_toggle != $past(mgr_toggle, 2); endproperty
  a_toggle: assert property (p_toggle) else $error("toggle stuck");
  property p_refuse;
    steady && mgr_done && !mgr_enabled |=> !$rose(irq) ##1 mgr_toggle == $past(mgr_toggle, 2);
  endproperty
  a_refuse: assert property (p_refuse) else $error("disabled slot served");
  property p_use_y; mgr_use_y |-> mgr_toggle; endproperty
  a_use_y: assert property (p_use_y) else $error("y without toggle");
  property p_stall; steady && mgr_stall |=> ##1 mgr_stalled; endproperty
  a_stall: assert property (p_stall) else $error("stall lost");
  property p_irq_cause; $rose(irq) |-> $past(mgr_done | write); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq from nowhere");
  c_done: cover property (go);
  c_stall: cover property (steady && mgr_stall);
  c_irq: cover property ($rose(irq));
endmodule // ep_desc_monitor
`default_nettype wire

// File: verif/mgr_model.sv
// buffer manager stand-in: selects a slot, then pulses done or stall
// assumes the bench calls evt just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module mgr_model (
  input wire logic clk,
  output logic [2:0] mgr_sel,
  output logic mgr_done,
  output logic [6:0] mgr_len,
  output logic mgr_stall
);
  initial begin
    mgr_sel = 3'h0;
    mgr_done = 1'b0;
    mgr_len = 7'h0;
    mgr_stall = 1'b0;
  end
  task evt(input logic [2:0] s, input logic [6:0] l, input logic st);
    mgr_sel <= s;
    mgr_len <= l > 7'h40 ? 7'h40 : l;
    @(posedge clk);
    mgr_done <= !st;
    mgr_stall <= st;
    @(posedge clk);
    mgr_done <= 1'b0;
    mgr_stall <= 1'b0;
    // length is meaningless once done drops
    mgr_len <= ~mgr_len;
    repeat (3) @(posedge clk);
  endtask
endmodule // mgr_model
`default_nettype wire

// File: verif/usb_endpoint_descriptor_bank_bench.sv
// bench for the descriptor bank: avalon tasks, manager model, checks
// assumes the manager model acts only when called from here
`timescale 1ns/1ps
`default_nettype none
`include "ep_desc_defines.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; $display("Error %0t: got %h", $time, a); end end
module usb_endpoint_descriptor_bank_bench;
  logic clk = 0, resetn = 0, read = 0, write = 0;
  logic [7:0] address = 0, rdata, base, cfg;
  logic [31:0] writedata = 0;
  logic [3:0] byteenable = 4'hf;
  logic [6:0] len;
  int seed = 43235, error_cnt = 0, checked = 0, d;
  wire [31:0] readdata;
  wire [10:0] mgr_start_addr;
  wire [6:0] mgr_len, mgr_count, mgr_size;
  wire [2:0] mgr_sel;
  wire waitrequest, mgr_done, mgr_stall, mgr_use_y, mgr_enabled, mgr_stalled, mgr_buf_nak, mgr_toggle, irq;
  always #25 clk = ~clk;
  usb_endpoint_descriptor_bank dut (.clk(clk), .resetn(resetn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .mgr_sel(mgr_sel), .mgr_done(mgr_done), .mgr_len(mgr_len), .mgr_stall(mgr_stall),
    .mgr_start_addr(mgr_start_addr), .mgr_use_y(mgr_use_y), .mgr_enabled(mgr_enabled),
    .mgr_stalled(mgr_stalled), .mgr_buf_nak(mgr_buf_nak), .mgr_count(mgr_count), .mgr_size(mgr_size),
    .mgr_toggle(mgr_toggle), .irq(irq));
  mgr_model mgr (.clk(clk), .mgr_sel(mgr_sel), .mgr_done(mgr_done), .mgr_len(mgr_len), .mgr_stall(mgr_stall));
  //////////////////////////////////////////////////////////////
  function automatic logic [7:0] ra(input int s, input int o);
    return 8'(s * `DESC_STRIDE + o * 4);
  endfunction
  task bus(input logic w, input logic [7:0] a, input logic [7:0] wd, input logic [3:0] be);
    address <= a;
    writedata <= {24'h0, wd};
    byteenable <= be;
    write <= w;
    read <= !w;
    @(posedge clk);
    while (waitrequest !== 1'b0)
      @(posedge clk);
    rdata = readdata[7:0];
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] wd);
    bus(1'b1, a, wd, 4'hf);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'hf);
    `CHK(rdata, e)
  endtask
  task give_verdict;
    if (error_cnt == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////
  initial begin
    repeat (4000) @(posedge clk);
    error_cnt++;
    give_verdict;
  end
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    for (d = 0; d < 6; d++) begin
      base = $random(seed);
      len = 7'({$random(seed)} % 65);
      rd(ra(d, `OFF_CONFIG), 8'h00);
      wr(ra(d, `OFF_X_BASE), base);
      wr(ra(d, `OFF_Y_BASE), ~base);
      // firmware never sets the isochronous bit; reserved bits are poked to prove they read zero
      cfg = 8'($random(seed)) & 8'hbf | 8'h03;
      wr(ra(d, `OFF_CONFIG), cfg);
      rd(ra(d, `OFF_CONFIG), cfg & 8'hfc);
      wr(ra(d, `OFF_SIZE), 8'hc0);
      rd(ra(d, `OFF_SIZE), 8'h40);
      rd(ra(d, `OFF_SPARE_A), 8'h00);
      bus(1'b1, ra(d, `OFF_X_COUNT), 8'h05, 4'he);
      rd(ra(d, `OFF_X_COUNT), 8'h00);
      wr(ra(d, `OFF_CONFIG), 8'h84);
      wr(`ADDR_IRQ_MASK, 8'h3f);
      mgr.evt(d, len, 1'b0);
      `CHK(mgr_start_addr, {base, 3'h0})
      `CHK(irq, 1'b1)
      `CHK(mgr_size, 7'h40)
      rd(ra(d, `OFF_X_COUNT), d < 3 ? {1'b1, len} : 8'h80);
      rd(ra(d, `OFF_CONFIG), 8'ha4);
      rd(`ADDR_IRQ_STATUS, 8'(1 << d));
      wr(`ADDR_IRQ_STATUS, 8'h3f);
      `CHK(irq, 1'b0)
      wr(ra(d, `OFF_CONFIG), 8'hb4);
      wr(`ADDR_IRQ_MASK, 8'h00);
      `CHK(mgr_use_y, 1'b1)
      `CHK(mgr_start_addr, {~base, 3'h0})
      mgr.evt(d, 7'h40, 1'b0);
      `CHK(irq, 1'b0)
      rd(`ADDR_IRQ_STATUS, 8'(1 << d));
      wr(`ADDR_IRQ_STATUS, 8'h3f);
      rd(ra(d, `OFF_Y_COUNT), d < 3 ? 8'hc0 : 8'h80);
      rd(ra(d, `OFF_Y_BASE), ~base);
      wr(ra(d, `OFF_CONFIG), 8'h04);
      wr(`ADDR_IRQ_MASK, 8'h3f);
      mgr.evt(d, len, 1'b0);
      `CHK(irq, 1'b0)
      rd(ra(d, `OFF_CONFIG), 8'h04);
      mgr.evt(d, 7'h00, 1'b1);
      `CHK(mgr_stalled, 1'b1)
      rd(ra(d, `OFF_CONFIG), 8'h0c);
      wr(ra(d, `OFF_CONFIG), 8'h00);
      rd(ra(d, `OFF_CONFIG), 8'h00);
      // served but interrupt enable clear: no status bit may appear
      wr(ra(d, `OFF_CONFIG), 8'h80);
      mgr.evt(d, len, 1'b0);
      `CHK(irq, 1'b0)
      rd(`ADDR_IRQ_STATUS, 8'h00);
      rd(ra(d, `OFF_CONFIG), 8'ha0);
    end
    // mid-run reset must wipe the configuration byte, its stall bit and the pending interrupt
    wr(`ADDR_IRQ_MASK, 8'h3f);
    wr(ra(0, `OFF_CONFIG), 8'h9c);
    mgr.evt(0, 7'h01, 1'b0);
    `CHK(irq, 1'b1)
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    `CHK(irq, 1'b0)
    rd(ra(0, `OFF_CONFIG), 8'h00);
    rd(`ADDR_IRQ_STATUS, 8'h00);
    rd(8'hd0, 8'h00);
    give_verdict;
  end
endmodule // usb_endpoint_descriptor_bank_bench
bind usb_endpoint_descriptor_bank ep_desc_monitor mon (.clk(clk), .resetn(resetn), .write(write),
  .mgr_sel(mgr_sel), .mgr_done(mgr_done), .mgr_len(mgr_len), .mgr_stall(mgr_stall),
  .mgr_start_addr(mgr_start_addr), .mgr_use_y(mgr_use_y), .mgr_enabled(mgr_enabled),
  .mgr_stalled(mgr_stalled), .mgr_buf_nak(mgr_buf_nak), .mgr_count(mgr_count),
  .mgr_toggle(mgr_toggle), .irq(irq));
`default_nettype wire
